// ### pkg/adc_cfg_pkg.sv
// Register map, field positions and shared types of the converter output block.
package adc_cfg_pkg;
  localparam int ADDR_W     = 5;
  localparam int REG_W      = 11;
  localparam int FRAME_W    = 16;
  localparam int SMP_W      = 14;
  localparam int LANE_W     = 7;
  localparam int FIFO_DEPTH = 8;

  localparam logic [3:0] ADDR_LAST_BIT  = 4'h4;
  localparam logic [3:0] FRAME_LAST_BIT = 4'hf;

  localparam logic [ADDR_W-1:0] OFS_PWR = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_TIM = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_ORD = 5'h09;
  localparam logic [ADDR_W-1:0] OFS_FMT = 5'h0a;
  localparam logic [ADDR_W-1:0] OFS_CUL = 5'h0b;
  localparam logic [ADDR_W-1:0] OFS_CUH = 5'h0c;

  // Writable bits of each register; all others read as zero.
  localparam logic [REG_W-1:0] MASK_PWR = 11'h725;
  localparam logic [REG_W-1:0] MASK_TIM = 11'h700;
  localparam logic [REG_W-1:0] MASK_ORD = 11'h400;
  localparam logic [REG_W-1:0] MASK_FMT = 11'h4e0;
  localparam logic [REG_W-1:0] MASK_CUL = 11'h7fc;
  localparam logic [REG_W-1:0] MASK_CUH = 11'h71f;
  localparam logic [REG_W-1:0] RST_REG  = 11'h000;

  localparam int B_STBY     = 0;
  localparam int B_PDN_CLK  = 2;
  localparam int B_SWRST    = 4;
  localparam int B_REF      = 5;
  localparam int B_LVDS     = 8;
  localparam int B_CGAIN    = 9;
  localparam int B_PDN_OBUF = 10;
  localparam int B_CPOS     = 8;
  localparam int B_CEDGE    = 9;
  localparam int B_DPOS     = 10;
  localparam int B_ORD      = 10;
  localparam int B_FMT      = 10;
  localparam int PAT_LSB    = 5;
  localparam int CUL_LSB    = 2;
  localparam int CUH_LSB    = 0;
  localparam int FG_LSB     = 8;

  localparam int CLKOUT_SHIFT_PS = 400;

  localparam logic [SMP_W-1:0] WORD_ZERO = 14'h0000;
  localparam logic [SMP_W-1:0] WORD_ONES = 14'h3fff;
  localparam logic [SMP_W-1:0] TOGGLE_A  = 14'h2aaa;
  localparam logic [SMP_W-1:0] TOGGLE_B  = 14'h1555;
  localparam logic [SMP_W-1:0] RAMP_STEP = 14'h0001;

  typedef enum logic [2:0] {
    PAT_ADC    = 3'h0,
    PAT_ZERO   = 3'h1,
    PAT_ONES   = 3'h2,
    PAT_TOGGLE = 3'h3,
    PAT_RAMP   = 3'h4,
    PAT_CUSTOM = 3'h5
  } pattern_e;

  typedef enum logic [2:0] {
    SER_IDLE  = 3'b001,
    SER_SHIFT = 3'b010,
    SER_DONE  = 3'b100
  } ser_state_e;

  typedef struct packed {
    logic             pdn_obuf;
    logic             pdn_clk;
    logic             data_delay;
    logic             clk_edge_fall;
    logic             clk_shift;
    logic             lvds_sel;
    logic             bit_wise;
    logic             sample_number_format;
    logic [2:0]       pattern;
    logic [SMP_W-1:0] custom;
  } fmt_cfg_s;

  typedef struct packed {
    logic       standby;
    logic       ref_external;
    logic       lvds_sel;
    logic       coarse_gain;
    logic [2:0] fine_gain;
  } analog_cfg_s;
endpackage

// ### verilog/adc_config_output_format.sv
// Serial configuration registers and output formatting of the converter.

// Two-clock FIFO with gray-coded pointers between the core and sample clocks.
module cdc_fifo #(
  parameter int W     = 14,
  parameter int DEPTH = 8
) (
  input  wire logic         wr_clk,
  input  wire logic         rd_clk,
  input  wire logic         rstn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wbin_ff;
  logic [AW:0]  rbin_ff;
  logic [AW:0]  wgray_ff;
  logic [AW:0]  rgray_ff;
  logic [AW:0]  rgray_s1_ff;
  logic [AW:0]  rgray_s2_ff;
  logic [AW:0]  wgray_s1_ff;
  logic [AW:0]  wgray_s2_ff;
  logic [AW:0]  nxt_wbin;
  logic [AW:0]  nxt_rbin;
  logic         push;
  logic         pop;

  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign nxt_wbin  = wbin_ff + {{AW{1'b0}}, push};
  assign nxt_rbin  = rbin_ff + {{AW{1'b0}}, pop};
  assign in_ready  = wgray_ff !=
                     {~rgray_s2_ff[AW:AW-1], rgray_s2_ff[AW-2:0]};
  assign out_valid = rgray_ff != wgray_s2_ff;
  assign out_data  = mem[rbin_ff[AW-1:0]];

  always_ff @(posedge wr_clk) begin
    if (push) begin
      mem[wbin_ff[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge wr_clk or negedge rstn) begin
    if (!rstn) begin
      wbin_ff     <= '0;
      wgray_ff    <= '0;
      rgray_s1_ff <= '0;
      rgray_s2_ff <= '0;
    end else begin
      wbin_ff     <= nxt_wbin;
      wgray_ff    <= nxt_wbin ^ (nxt_wbin >> 1);
      rgray_s1_ff <= rgray_ff;
      rgray_s2_ff <= rgray_s1_ff;
    end
  end

  always_ff @(posedge rd_clk or negedge rstn) begin
    if (!rstn) begin
      rbin_ff     <= '0;
      rgray_ff    <= '0;
      wgray_s1_ff <= '0;
      wgray_s2_ff <= '0;
    end else begin
      rbin_ff     <= nxt_rbin;
      rgray_ff    <= nxt_rbin ^ (nxt_rbin >> 1);
      wgray_s1_ff <= wgray_ff;
      wgray_s2_ff <= wgray_s1_ff;
    end
  end
endmodule

module adc_config_output_format (
  input  wire logic                        core_clk,
  input  wire logic                        rstn,
  input  wire logic                        smp_clk,
  input  wire logic                        sen_n,
  input  wire logic                        sclk,
  input  wire logic                        sdata,
  output logic                             sdata_out,
  input  wire logic                        adc_valid,
  output logic                             adc_ready,
  input  wire logic [13:0]                 adc_data,
  output adc_cfg_pkg::analog_cfg_s         analog_cfg,
  output logic [13:0]                      sample_word,
  output logic [6:0]                       ddr_rise_lane,
  output logic [6:0]                       ddr_fall_lane,
  output logic                             data_oe,
  output logic                             fwd_clock_positive,
  output logic                             fwd_clock_oe,
  output logic                             clk_shift_en
);
  localparam int RW = adc_cfg_pkg::REG_W;
  localparam int SW = adc_cfg_pkg::SMP_W;

  logic sen_n_s1_ff, sen_n_s2_ff;
  logic sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
  logic sdata_s1_ff, sdata_s2_ff;
  adc_cfg_pkg::ser_state_e st_ff, nxt_st;
  logic [3:0]                      cnt_ff;
  logic [adc_cfg_pkg::FRAME_W-2:0] sh_ff;
  logic [RW-1:0]                   rd_sh_ff;
  logic [RW-1:0] pwr_ff, tim_ff, ord_ff, fmt_ff, cul_ff, cuh_ff;
  logic [adc_cfg_pkg::FRAME_W-1:0] frame;
  logic [adc_cfg_pkg::ADDR_W-1:0]  wr_addr;
  logic [RW-1:0]                   wr_data;
  logic sclk_rise, shift_en, wr_stb, addr_done, swrst;
  adc_cfg_pkg::fmt_cfg_s cfg_core, cfg_s1_ff, cfg_s2_ff;
  adc_cfg_pkg::fmt_cfg_s cfg_mid_ff, cfg_hold_ff;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [RW-1:0] reg_read(input logic [4:0] a);
    reg_read = hit(a, adc_cfg_pkg::OFS_PWR) ? pwr_ff :
               hit(a, adc_cfg_pkg::OFS_TIM) ? tim_ff :
               hit(a, adc_cfg_pkg::OFS_ORD) ? ord_ff :
               hit(a, adc_cfg_pkg::OFS_FMT) ? fmt_ff :
               hit(a, adc_cfg_pkg::OFS_CUL) ? cul_ff :
               hit(a, adc_cfg_pkg::OFS_CUH) ? cuh_ff : '0;
  endfunction

  // Serial pins are asynchronous to core_clk, so sen_n and sdata pass two flops and sclk three.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sen_n_s1_ff <= 1'b1;
      sen_n_s2_ff <= 1'b1;
      sclk_s1_ff  <= 1'b0;
      sclk_s2_ff  <= 1'b0;
      sclk_s3_ff  <= 1'b0;
      sdata_s1_ff <= 1'b0;
      sdata_s2_ff <= 1'b0;
    end else begin
      sen_n_s1_ff <= sen_n;
      sen_n_s2_ff <= sen_n_s1_ff;
      sclk_s1_ff  <= sclk;
      sclk_s2_ff  <= sclk_s1_ff;
      sclk_s3_ff  <= sclk_s2_ff;
      sdata_s1_ff <= sdata;
      sdata_s2_ff <= sdata_s1_ff;
    end
  end

  assign sclk_rise = sclk_s2_ff & ~sclk_s3_ff;
  assign shift_en  = (st_ff == adc_cfg_pkg::SER_SHIFT) & ~sen_n_s2_ff &
                     sclk_rise;
  assign frame     = {sh_ff, sdata_s2_ff};
  assign wr_addr   = frame[adc_cfg_pkg::FRAME_W-1:RW];
  assign wr_data   = frame[RW-1:0];
  assign wr_stb    = shift_en & (cnt_ff == adc_cfg_pkg::FRAME_LAST_BIT);
  assign addr_done = shift_en & (cnt_ff == adc_cfg_pkg::ADDR_LAST_BIT);
  assign swrst     = wr_stb & hit(wr_addr, adc_cfg_pkg::OFS_PWR) &
                     wr_data[adc_cfg_pkg::B_SWRST];
  assign sdata_out = rd_sh_ff[RW-1];

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      adc_cfg_pkg::SER_IDLE: begin
        if (!sen_n_s2_ff) begin
          nxt_st = adc_cfg_pkg::SER_SHIFT;
        end
      end
      adc_cfg_pkg::SER_SHIFT: begin
        if (sen_n_s2_ff) begin
          nxt_st = adc_cfg_pkg::SER_IDLE;
        end else if (wr_stb) begin
          nxt_st = adc_cfg_pkg::SER_DONE;
        end
      end
      adc_cfg_pkg::SER_DONE: begin
        if (sen_n_s2_ff) begin
          nxt_st = adc_cfg_pkg::SER_IDLE;
        end
      end
      default: begin
        nxt_st = adc_cfg_pkg::SER_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff    <= adc_cfg_pkg::SER_IDLE;
      cnt_ff   <= '0;
      sh_ff    <= '0;
      rd_sh_ff <= '0;
    end else begin
      st_ff    <= nxt_st;
      cnt_ff   <= (st_ff != adc_cfg_pkg::SER_SHIFT) ? 4'h0 :
                  cnt_ff + {3'h0, shift_en};
      sh_ff    <= shift_en ? frame[adc_cfg_pkg::FRAME_W-2:0] : sh_ff;
      rd_sh_ff <= addr_done ? reg_read(frame[adc_cfg_pkg::ADDR_W-1:0]) :
                  shift_en ? {rd_sh_ff[RW-2:0], 1'b0} : rd_sh_ff;
    end
  end

  // The reset bit is not held in the mask, so it always reads as zero.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pwr_ff <= adc_cfg_pkg::RST_REG;
      tim_ff <= adc_cfg_pkg::RST_REG;
      ord_ff <= adc_cfg_pkg::RST_REG;
      fmt_ff <= adc_cfg_pkg::RST_REG;
      cul_ff <= adc_cfg_pkg::RST_REG;
      cuh_ff <= adc_cfg_pkg::RST_REG;
    end else if (swrst) begin
      pwr_ff <= adc_cfg_pkg::RST_REG;
      tim_ff <= adc_cfg_pkg::RST_REG;
      ord_ff <= adc_cfg_pkg::RST_REG;
      fmt_ff <= adc_cfg_pkg::RST_REG;
      cul_ff <= adc_cfg_pkg::RST_REG;
      cuh_ff <= adc_cfg_pkg::RST_REG;
    end else if (wr_stb) begin
      if (hit(wr_addr, adc_cfg_pkg::OFS_PWR)) begin
        pwr_ff <= wr_data & adc_cfg_pkg::MASK_PWR;
      end
      if (hit(wr_addr, adc_cfg_pkg::OFS_TIM)) begin
        tim_ff <= wr_data & adc_cfg_pkg::MASK_TIM;
      end
      if (hit(wr_addr, adc_cfg_pkg::OFS_ORD)) begin
        ord_ff <= wr_data & adc_cfg_pkg::MASK_ORD;
      end
      if (hit(wr_addr, adc_cfg_pkg::OFS_FMT)) begin
        fmt_ff <= wr_data & adc_cfg_pkg::MASK_FMT;
      end
      if (hit(wr_addr, adc_cfg_pkg::OFS_CUL)) begin
        cul_ff <= wr_data & adc_cfg_pkg::MASK_CUL;
      end
      if (hit(wr_addr, adc_cfg_pkg::OFS_CUH)) begin
        cuh_ff <= wr_data & adc_cfg_pkg::MASK_CUH;
      end
    end
  end

  assign analog_cfg.standby      = pwr_ff[adc_cfg_pkg::B_STBY];
  assign analog_cfg.ref_external = pwr_ff[adc_cfg_pkg::B_REF];
  assign analog_cfg.lvds_sel     = pwr_ff[adc_cfg_pkg::B_LVDS];
  assign analog_cfg.coarse_gain  = pwr_ff[adc_cfg_pkg::B_CGAIN];
  assign analog_cfg.fine_gain    = cuh_ff[adc_cfg_pkg::FG_LSB +: 3];

  assign cfg_core.pdn_obuf      = pwr_ff[adc_cfg_pkg::B_PDN_OBUF];
  assign cfg_core.pdn_clk       = pwr_ff[adc_cfg_pkg::B_PDN_CLK];
  assign cfg_core.data_delay    = tim_ff[adc_cfg_pkg::B_DPOS];
  assign cfg_core.clk_edge_fall = tim_ff[adc_cfg_pkg::B_CEDGE];
  assign cfg_core.clk_shift     = tim_ff[adc_cfg_pkg::B_CPOS];
  assign cfg_core.lvds_sel      = pwr_ff[adc_cfg_pkg::B_LVDS];
  assign cfg_core.bit_wise      = ord_ff[adc_cfg_pkg::B_ORD];
  assign cfg_core.sample_number_format = fmt_ff[adc_cfg_pkg::B_FMT];
  assign cfg_core.pattern       = fmt_ff[adc_cfg_pkg::PAT_LSB +: 3];
  assign cfg_core.custom        = {cuh_ff[adc_cfg_pkg::CUH_LSB +: 5],
                                   cul_ff[adc_cfg_pkg::CUL_LSB +: 9]};

  // A multi-bit change may be caught half old and half new by the
  // synchroniser, so a value is used only once two samples in a row agree.
  always_ff @(posedge smp_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_s1_ff   <= '0;
      cfg_mid_ff  <= '0;
      cfg_hold_ff <= '0;
      cfg_s2_ff   <= '0;
    end else begin
      cfg_s1_ff   <= cfg_core;
      cfg_mid_ff  <= cfg_s1_ff;
      cfg_hold_ff <= cfg_mid_ff;
      cfg_s2_ff   <= (cfg_hold_ff == cfg_mid_ff) ? cfg_hold_ff : cfg_s2_ff;
    end
  end

  logic            fifo_valid, drain, pop;
  logic [SW-1:0]   fifo_data, hold_ff, adc_word, ramp_ff, toggle_word;
  logic            toggle_ff;
  logic [SW-1:0]   sel_word, word_ff, word_neg_ff;
  logic [6:0]      even_bits, odd_bits, nxt_rise, nxt_fall;
  logic [6:0]      rise_ff, fall_ff, rise_neg_ff, fall_neg_ff;
  logic            lane_bitwise;

  // Stalling the drain outside sample mode lets the FIFO fill and push back.
  assign drain = (cfg_s2_ff.pattern == adc_cfg_pkg::PAT_ADC) &
                 ~cfg_s2_ff.pdn_obuf;
  assign pop   = fifo_valid & drain;

  cdc_fifo #(
    .W     (SW),
    .DEPTH (adc_cfg_pkg::FIFO_DEPTH)
  ) u_fifo (
    .wr_clk    (core_clk),
    .rd_clk    (smp_clk),
    .rstn      (rstn),
    .in_valid  (adc_valid & ~pwr_ff[adc_cfg_pkg::B_STBY]),
    .in_ready  (adc_ready),
    .in_data   (adc_data),
    .out_valid (fifo_valid),
    .out_ready (drain),
    .out_data  (fifo_data)
  );

  // The core delivers offset binary; flipping the MSB gives two's complement.
  assign adc_word = cfg_s2_ff.sample_number_format ? hold_ff :
                    {~hold_ff[SW-1], hold_ff[SW-2:0]};
  assign toggle_word = toggle_ff ? adc_cfg_pkg::TOGGLE_B :
                       adc_cfg_pkg::TOGGLE_A;

  assign sel_word =
    (cfg_s2_ff.pattern == adc_cfg_pkg::PAT_ADC)    ? adc_word :
    (cfg_s2_ff.pattern == adc_cfg_pkg::PAT_ONES)   ? adc_cfg_pkg::WORD_ONES :
    (cfg_s2_ff.pattern == adc_cfg_pkg::PAT_TOGGLE) ? toggle_word :
    (cfg_s2_ff.pattern == adc_cfg_pkg::PAT_RAMP)   ? ramp_ff :
    (cfg_s2_ff.pattern == adc_cfg_pkg::PAT_CUSTOM) ? cfg_s2_ff.custom :
    adc_cfg_pkg::WORD_ZERO;

  for (genvar i = 0; i < adc_cfg_pkg::LANE_W; i++) begin : g_lane
    assign even_bits[i] = sel_word[2*i];
    assign odd_bits[i]  = sel_word[2*i+1];
  end

  assign lane_bitwise = cfg_s2_ff.lvds_sel & cfg_s2_ff.bit_wise;
  assign nxt_rise = lane_bitwise ? even_bits : sel_word[6:0];
  assign nxt_fall = lane_bitwise ? odd_bits : sel_word[13:7];

  always_ff @(posedge smp_clk or negedge rstn) begin
    if (!rstn) begin
      hold_ff   <= '0;
      ramp_ff   <= '0;
      toggle_ff <= 1'b0;
      word_ff   <= '0;
      rise_ff   <= '0;
      fall_ff   <= '0;
    end else begin
      hold_ff   <= pop ? fifo_data : hold_ff;
      ramp_ff   <= (cfg_s2_ff.pattern == adc_cfg_pkg::PAT_RAMP) ?
                   ramp_ff + adc_cfg_pkg::RAMP_STEP : '0;
      toggle_ff <= (cfg_s2_ff.pattern == adc_cfg_pkg::PAT_TOGGLE) &
                   ~toggle_ff;
      word_ff   <= sel_word;
      rise_ff   <= nxt_rise;
      fall_ff   <= nxt_fall;
    end
  end

  // Falling-edge copies give the half-cycle later data transition.
  always_ff @(negedge smp_clk or negedge rstn) begin
    if (!rstn) begin
      word_neg_ff <= '0;
      rise_neg_ff <= '0;
      fall_neg_ff <= '0;
    end else begin
      word_neg_ff <= word_ff;
      rise_neg_ff <= rise_ff;
      fall_neg_ff <= fall_ff;
    end
  end

  assign sample_word   = cfg_s2_ff.data_delay ? word_neg_ff : word_ff;
  assign ddr_rise_lane = cfg_s2_ff.data_delay ? rise_neg_ff : rise_ff;
  assign ddr_fall_lane = cfg_s2_ff.data_delay ? fall_neg_ff : fall_ff;
  assign data_oe       = ~cfg_s2_ff.pdn_obuf;
  assign fwd_clock_oe  = ~(cfg_s2_ff.pdn_obuf | cfg_s2_ff.pdn_clk);
  assign fwd_clock_positive = smp_clk ^ cfg_s2_ff.clk_edge_fall;
  // The pad delay line adds the fixed CLKOUT_SHIFT_PS when enabled.
  assign clk_shift_en  = cfg_s2_ff.clk_shift;

  sequence s_pat_run(logic [2:0] code);
    (cfg_s2_ff.pattern == code) [*2];
  endsequence

  property p_swrst_clears;
    @(posedge core_clk) disable iff (!rstn)
      swrst |=> (pwr_ff == '0) && (tim_ff == '0) && (fmt_ff == '0) &&
                (ord_ff == '0) && (cul_ff == '0) &&
                (cuh_ff == '0) ##1 (pwr_ff[adc_cfg_pkg::B_SWRST] == 1'b0);
  endproperty
  a_swrst_clears: assert property (p_swrst_clears)
    else $error("software reset did not clear registers");

  property p_standby_set;
    @(posedge core_clk) disable iff (!rstn)
      wr_stb && hit(wr_addr, adc_cfg_pkg::OFS_PWR) && !swrst
      |=> analog_cfg.standby == $past(wr_data[adc_cfg_pkg::B_STBY]);
  endproperty
  a_standby_set: assert property (p_standby_set)
    else $error("standby output does not follow write");

  property p_multi_field;
    @(posedge core_clk) disable iff (!rstn)
      wr_stb && hit(wr_addr, adc_cfg_pkg::OFS_TIM)
      |=> tim_ff == ($past(wr_data) & adc_cfg_pkg::MASK_TIM);
  endproperty
  a_multi_field: assert property (p_multi_field)
    else $error("timing register fields not all updated");

  property p_obuf_off;
    @(posedge smp_clk) disable iff (!rstn)
      cfg_s2_ff.pdn_obuf |-> !data_oe && !fwd_clock_oe && !drain;
  endproperty
  a_obuf_off: assert property (p_obuf_off)
    else $error("drivers enabled while output buffers powered down");

  property p_ramp_step;
    @(posedge smp_clk) disable iff (!rstn)
      s_pat_run(adc_cfg_pkg::PAT_RAMP) |=>
        word_ff == $past(word_ff) + adc_cfg_pkg::RAMP_STEP;
  endproperty
  a_ramp_step: assert property (p_ramp_step)
    else $error("ramp did not step by one");

  property p_toggle;
    @(posedge smp_clk) disable iff (!rstn)
      s_pat_run(adc_cfg_pkg::PAT_TOGGLE) |=> (word_ff != $past(word_ff)) &&
        (word_ff == adc_cfg_pkg::TOGGLE_A || word_ff == adc_cfg_pkg::TOGGLE_B);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("toggle pattern wrong");

  property p_fixed_pat;
    @(posedge smp_clk) disable iff (!rstn)
      (cfg_s2_ff.pattern == adc_cfg_pkg::PAT_ONES) |=>
        word_ff == adc_cfg_pkg::WORD_ONES;
  endproperty
  a_fixed_pat: assert property (p_fixed_pat)
    else $error("all-ones pattern wrong");

  property p_custom;
    @(posedge smp_clk) disable iff (!rstn)
      (cfg_s2_ff.pattern == adc_cfg_pkg::PAT_CUSTOM) |=>
        word_ff == $past(cfg_s2_ff.custom);
  endproperty
  a_custom: assert property (p_custom)
    else $error("custom pattern word wrong");

  property p_lanes;
    @(posedge smp_clk) disable iff (!rstn)
      1'b1 |=> $past(lane_bitwise) ?
        (rise_ff[6] == word_ff[12] && fall_ff[0] == word_ff[1]) :
        (rise_ff == word_ff[6:0] && fall_ff == word_ff[13:7]);
  endproperty
  a_lanes: assert property (p_lanes)
    else $error("DDR lane ordering wrong");
endmodule

// ### tb/capture_model.sv
// Capture device model that latches the output word on the chosen edge.
module capture_model (
  input  wire logic        fwd_clk,
  input  wire logic        clk_oe,
  input  wire logic        edge_fall,
  input  wire logic [13:0] word,
  output logic      [13:0] cap
);
  timeunit 1ns;
  timeprecision 100ps;
  // A powered-down clock driver gives no capture edges at all.
  always @(fwd_clk) begin
    if (clk_oe && (fwd_clk ^ edge_fall))
      cap <= word;
  end
endmodule

// ### tb/tb_top.sv
// Self-checking bench of the converter register and output block.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk, smp_clk, rstn, sen_n, sclk, sdata, adc_valid;
  logic        sdo, adc_ready, data_oe, fwd_clk, fwd_oe, shift_en, efall;
  logic [13:0] adc_data, word, cap;
  logic [6:0]  rise_l, fall_l;
  logic [15:0] seen;
  logic [15:0] exp_q[$];
  logic [13:0] out_q[$];
  logic [10:0] mem[6];
  logic [4:0]  ofs[6] = '{5'h00, 5'h04, 5'h09, 5'h0a, 5'h0b, 5'h0c};
  logic [10:0] msk[6] = '{11'h725, 11'h700, 11'h400, 11'h4e0, 11'h7fc,
                          11'h71f};
  logic [12:0] pw[4] = '{13'h1004, 13'h0400, 13'h1801, 13'h1800};
  int          error_cnt = 0, tests_run = 0, cyc = 0;
  event        got;
  adc_cfg_pkg::analog_cfg_s acfg;

  adc_config_output_format i_adc_config_output_format (
    .core_clk(core_clk), .rstn(rstn), .smp_clk(smp_clk),
    .sen_n(sen_n), .sclk(sclk), .sdata(sdata), .sdata_out(sdo),
    .adc_valid(adc_valid), .adc_ready(adc_ready), .adc_data(adc_data),
    .analog_cfg(acfg), .sample_word(word), .ddr_rise_lane(rise_l),
    .ddr_fall_lane(fall_l), .data_oe(data_oe),
    .fwd_clock_positive(fwd_clk), .fwd_clock_oe(fwd_oe),
    .clk_shift_en(shift_en));
  capture_model i_capture_model (.fwd_clk(fwd_clk), .clk_oe(fwd_oe),
    .edge_fall(efall), .word(word), .cap(cap));

  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    smp_clk = 0;
    #7;
    forever #15 smp_clk = ~smp_clk;
  end

  task automatic check(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  initial forever begin
    @(got);
    check(seen, exp_q.pop_front());
  end
  task automatic note(input logic [15:0] s, input logic [15:0] e);
    exp_q.push_back(e);
    seen = s;
    ->got;
    #0;
  endtask

  // Every frame writes, so a read sends back the value it expects.
  task automatic xfer(input logic [4:0] a, input logic [10:0] d,
                      output logic [10:0] r);
    logic [15:0] f;
    f = {a, d};
    @(negedge core_clk);
    sen_n = 0;
    repeat (4) @(negedge core_clk);
    for (int i = 15; i >= 0; i--) begin
      sdata = f[i];
      sclk = 0;
      repeat (4) @(negedge core_clk);
      sclk = 1;
      repeat (5) @(negedge core_clk);
      if (i inside {[1:11]}) r[i-1] = sdo;
    end
    sclk = 0;
    sen_n = 1;
    repeat (6) @(negedge core_clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [10:0] e);
    logic [10:0] r;
    xfer(a, e, r);
    note({5'h0, r}, {5'h0, e});
  endtask
  task automatic wr(input logic [4:0] a, input logic [10:0] d);
    logic [10:0] r;
    xfer(a, d, r);
    repeat (12) @(negedge smp_clk);
  endtask
  task automatic drain(input logic [13:0] b);
    repeat (120) begin
      @(negedge smp_clk);
      if (word !== b) begin
        b = word;
        note({2'b0, word}, {2'b0, out_q.pop_front()});
      end
    end
    note(16'(out_q.size()), 16'h0);
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      end_sim();
    end
  end

  initial begin
    logic [13:0] a, b, cu;
    void'($urandom(33));
    {rstn, sen_n, sclk, sdata, adc_valid, efall} = 6'b010000;
    adc_data = 14'h0;
    repeat (6) @(negedge core_clk);
    rstn = 1;
    foreach (ofs[i]) rd(ofs[i], 11'h0);
    foreach (ofs[i]) begin
      mem[i] = 11'($urandom) & msk[i];
      wr(ofs[i], mem[i]);
    end
    wr(5'h01, 11'h7ff);
    rd(5'h01, 11'h0);
    foreach (ofs[i]) rd(ofs[i], mem[i]);
    note(16'(acfg), {9'h0, mem[0][0], mem[0][5], mem[0][8], mem[0][9],
         mem[5][10:8]});
    wr(5'h00, 11'h010);
    foreach (ofs[i]) rd(ofs[i], 11'h0);
    cu = 14'($urandom);
    wr(5'h0b, {cu[8:0], 2'b0});
    wr(5'h0c, {6'h0, cu[13:9]});
    for (int p = 1; p < 8; p++) begin
      wr(5'h0a, {3'h0, p[2:0], 5'h0});
      a = word;
      @(negedge smp_clk);
      b = word;
      if (p == 3)
        note({2'b0, a ^ b}, 16'h3fff);
      else if (p == 4)
        note({2'b0, b}, {2'b0, a + 14'h1});
      else
        note({2'b0, cap}, p == 2 ? 16'h3fff : p == 5 ? cu : 16'h0);
    end
    wr(5'h0a, 11'h0a0);
    for (int m = 0; m < 4; m++) begin
      wr(5'h00, {2'b0, m[0], 8'h0});
      wr(5'h09, {m[1], 10'h0});
      for (int k = 0; k < 7; k++) begin
        a[k] = m == 3 ? cu[2*k] : cu[k];
        b[k] = m == 3 ? cu[2*k+1] : cu[k+7];
      end
      note({2'b0, rise_l, fall_l}, {2'b0, a[6:0], b[6:0]});
    end
    wr(5'h0a, 11'h080);
    for (int t = 0; t < 2; t++) begin
      efall = t[0];
      wr(5'h04, {t[0] ? 3'h7 : 3'h0, 8'h0});
      @(posedge smp_clk);
      #1;
      a = word;
      note({15'h0, fwd_clk}, {15'h0, ~efall});
      note({15'h0, shift_en}, {15'h0, efall});
      @(negedge smp_clk);
      #1;
      note({2'b0, word}, {2'b0, a + {13'h0, efall}});
    end
    efall = 0;
    wr(5'h04, 11'h0);
    foreach (pw[i]) begin
      wr(5'h00, pw[i][10:0]);
      note({14'h0, data_oe, fwd_oe}, 16'(pw[i][12:11]));
    end
    // Patterns other than samples stall the drain, so the buffer fills.
    wr(5'h0a, 11'h420);
    @(negedge core_clk);
    for (int i = 0; i < 12; i++) begin
      a = {1'b1, 12'($urandom), i[0]};
      if (adc_ready) begin
        out_q.push_back(a);
        b = a;
      end
      adc_valid = adc_ready;
      adc_data = a;
      @(negedge core_clk);
    end
    adc_valid = 0;
    note({15'h0, adc_ready}, 16'h0);
    note(16'(out_q.size()), 16'h8);
    fork
      drain(14'h0);
      wr(5'h0a, 11'h400);
    join
    // A sample offered in standby is dropped and must never reach the output.
    wr(5'h00, 11'h001);
    @(negedge core_clk);
    adc_valid = 1;
    @(negedge core_clk);
    adc_valid = 0;
    wr(5'h00, 11'h000);
    wr(5'h0a, 11'h000);
    a = {1'b1, 12'($urandom), 1'b0};
    out_q.push_back(a ^ 14'h2000);
    @(negedge core_clk);
    adc_data = a;
    adc_valid = 1;
    @(negedge core_clk);
    adc_valid = 0;
    // The held sample already shows in two's complement before the new one.
    drain(b ^ 14'h2000);
    end_sim();
  end
endmodule
